// ---- design/ccde_pkg.sv ----
// shared constants for the clear/call/decrement execution core
package ccde_pkg;
  // widths
  localparam int unsigned INSTR_W = 12;
  localparam int unsigned PC_W    = 11;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 5;

  // instruction encodings
  localparam logic [11:0] OPC_NOP        = 12'h000;
  localparam logic [11:0] OPC_CLRACC     = 12'h040;
  localparam logic [11:0] OPC_WDCLR      = 12'h004;
  localparam logic [6:0]  OPC_CLRFILE_HI = 7'h03;
  localparam logic [5:0]  OPC_DEC_HI     = 6'h03;
  localparam logic [5:0]  OPC_COMP_HI    = 6'h09;
  localparam logic [5:0]  OPC_DECSKIP_HI = 6'h0B;
  localparam logic [3:0]  OPC_CALL_HI    = 4'h9;

  // instruction field positions
  localparam int unsigned DEST_BIT = 5;

  // status register fields
  localparam int unsigned ST_Z    = 2;
  localparam int unsigned ST_PD_N = 3;
  localparam int unsigned ST_TO_N = 4;
  localparam int unsigned ST_PA_LO = 5;
  localparam int unsigned ST_PA_HI = 6;
  localparam logic [7:0]  STATUS_RST = 8'h18;

  // control register fields
  localparam int unsigned CT_RUN  = 0;
  localparam int unsigned CT_PSA  = 1;
  localparam int unsigned CT_WDEN = 2;
  localparam logic [2:0]  CTRL_RST = 3'h0;

  // apb byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACCUM  = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0C;
  localparam logic [7:0] OFS_WDOG   = 8'h10;

  // reset values and prescaler maximum
  localparam logic [7:0]  ACCUM_RST = 8'h00;
  localparam logic [10:0] PC_RST    = 11'h000;
  localparam logic [7:0]  WDOG_RST  = 8'h00;
  localparam logic [7:0]  PRESC_RST = 8'h00;
  localparam logic [7:0]  PRESC_MAX = 8'hFF;
endpackage

// ---- design/ccde_exec_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries the instruction and operands into the decoder and its results back
interface ccde_exec_if;
  logic [11:0] ir;
  logic        flushed;
  logic [7:0]  file_val;
  logic [7:0]  result;
  logic        write_acc;
  logic        write_file;
  logic        z_we;
  logic        is_call;
  logic        skip_next;
  logic        wd_clear;

  modport core (output ir, flushed, file_val,
                input  result, write_acc, write_file, z_we, is_call, skip_next, wd_clear);
  modport alu  (input  ir, flushed, file_val,
                output result, write_acc, write_file, z_we, is_call, skip_next, wd_clear);
endinterface
`default_nettype wire

// ---- design/ccde_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
// combinational decode and result path for the instruction in execute
module ccde_alu (
  ccde_exec_if.alu ex
);
  logic       dest_file;
  logic [7:0] dec_val;

  assign dest_file = ex.ir[ccde_pkg::DEST_BIT];
  assign dec_val   = ex.file_val - 8'h01;

  // decode one instruction; a flushed slot decodes as no operation
  always_comb begin
    ex.result     = 8'h00;
    ex.write_acc  = 1'b0;
    ex.write_file = 1'b0;
    ex.z_we       = 1'b0;
    ex.is_call    = 1'b0;
    ex.skip_next  = 1'b0;
    ex.wd_clear   = 1'b0;
    if (!ex.flushed) begin
      if (ex.ir == ccde_pkg::OPC_CLRACC) begin
        ex.result    = 8'h00;
        ex.write_acc = 1'b1;
        ex.z_we      = 1'b1;
      end else if (ex.ir == ccde_pkg::OPC_WDCLR) begin
        ex.wd_clear = 1'b1;
      end else if (ex.ir[11:5] == ccde_pkg::OPC_CLRFILE_HI) begin
        ex.result     = 8'h00;
        ex.write_file = 1'b1;
        ex.z_we       = 1'b1;
      end else if (ex.ir[11:6] == ccde_pkg::OPC_COMP_HI) begin
        ex.result     = ~ex.file_val;
        ex.write_acc  = !dest_file;
        ex.write_file = dest_file;
        ex.z_we       = 1'b1;
      end else if (ex.ir[11:6] == ccde_pkg::OPC_DEC_HI) begin
        ex.result     = dec_val;
        ex.write_acc  = !dest_file;
        ex.write_file = dest_file;
        ex.z_we       = 1'b1;
      end else if (ex.ir[11:6] == ccde_pkg::OPC_DECSKIP_HI) begin
        ex.result     = dec_val;
        ex.write_acc  = !dest_file;
        ex.write_file = dest_file;
        ex.skip_next  = (dec_val == 8'h00);
      end else if (ex.ir[11:8] == ccde_pkg::OPC_CALL_HI) begin
        ex.is_call = 1'b1;
      end
    end
  end
endmodule // ccde_alu
`default_nettype wire

// ---- design/ccde_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccde_core #(
  parameter int unsigned WDOG_W  = 8,
  parameter int unsigned PRESC_W = 8
) (
  // clock and reset
  input  wire  logic        ref_clk,
  input  wire  logic        arst_n,
  // apb slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // program memory
  output logic [10:0]       instr_addr,
  input  wire  logic [11:0] instr_data,
  // file register array
  output logic [4:0]        file_addr,
  input  wire  logic [7:0]  file_rdata,
  output logic [7:0]        file_wdata,
  output logic              file_we,
  // return stack
  output logic              stack_push,
  output logic [10:0]       stack_data,
  // watchdog
  output logic              watchdog_timeout,
  output logic              watchdog_cleared
);

  ccde_exec_if ex ();

  logic [2:0]         ctrl;
  logic [7:0]         status;
  logic [7:0]         accum;
  logic [10:0]        pc;
  logic [11:0]        ir;
  logic               flushed;
  logic [WDOG_W-1:0]  watchdog_counter;
  logic [PRESC_W-1:0] prescaler;
  logic               running;
  logic               exec;
  logic               apb_wr;
  logic               apb_rd;
  logic               hit;
  logic [10:0]        next_pc;
  logic [10:0]        call_target;
  logic               wd_tick;
  logic               wd_wrap;
  logic               timeout_flag_n;
  logic               powerdown_flag_n;
  logic               zero_flag;
  logic [1:0]         page;

  ccde_alu u_alu (
    .ex (ex)
  );

  // operands into the decoder
  assign ex.ir       = ir;
  assign ex.flushed  = flushed;
  assign ex.file_val = file_rdata;

  assign running = ctrl[ccde_pkg::CT_RUN];
  assign exec    = running;

  // apb handshake, zero wait states
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign hit    = (paddr == ccde_pkg::OFS_CTRL) || (paddr == ccde_pkg::OFS_STATUS) ||
                  (paddr == ccde_pkg::OFS_ACCUM) || (paddr == ccde_pkg::OFS_PC) ||
                  (paddr == ccde_pkg::OFS_WDOG);
  assign pslverr = psel && penable && !hit;

  // read mux, unmapped reads as zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      unique case (paddr)
        ccde_pkg::OFS_CTRL:   prdata = {29'h0, ctrl};
        ccde_pkg::OFS_STATUS: prdata = {24'h00_0000, status};
        ccde_pkg::OFS_ACCUM:  prdata = {24'h00_0000, accum};
        ccde_pkg::OFS_PC:     prdata = {21'h0, pc};
        ccde_pkg::OFS_WDOG:   prdata = {16'h0000, prescaler[7:0], watchdog_counter[7:0]};
        default:              prdata = 32'h0000_0000;
      endcase
    end
  end

  // memory and file port drive
  assign instr_addr = pc;
  assign file_addr  = ir[4:0];
  assign file_wdata = ex.result;
  assign file_we    = exec && ex.write_file;

  // return address push
  assign stack_push = exec && ex.is_call;
  assign stack_data = pc;

  // call destination built from page bits and operand
  assign call_target = {status[ccde_pkg::ST_PA_HI:ccde_pkg::ST_PA_LO], 1'b0, ir[7:0]};

  // next fetch address
  always_comb begin
    next_pc = pc + 11'h001;
    if (ex.is_call) begin
      next_pc = call_target;
    end
  end

  // control register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= ccde_pkg::CTRL_RST;
    end else if (apb_wr && paddr == ccde_pkg::OFS_CTRL) begin
      ctrl <= pwdata[2:0];
    end
  end

  // program counter; an apb write restarts fetch there
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc <= ccde_pkg::PC_RST;
    end else if (apb_wr && paddr == ccde_pkg::OFS_PC) begin
      pc <= pwdata[10:0];
    end else if (exec) begin
      pc <= next_pc;
    end
  end

  // instruction register and prefetch discard
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir      <= ccde_pkg::OPC_NOP;
      flushed <= 1'b1;
    end else if (apb_wr && paddr == ccde_pkg::OFS_PC) begin
      flushed <= 1'b1;
    end else if (exec) begin
      ir      <= instr_data;
      flushed <= ex.is_call || ex.skip_next;
    end
  end

  // working accumulator; the core wins over a same-cycle apb write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      accum <= ccde_pkg::ACCUM_RST;
    end else if (exec && ex.write_acc) begin
      accum <= ex.result;
    end else if (apb_wr && paddr == ccde_pkg::OFS_ACCUM) begin
      accum <= pwdata[7:0];
    end
  end

  // zero flag; call and decrement-skip never touch it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_flag <= ccde_pkg::STATUS_RST[ccde_pkg::ST_Z];
    end else if (exec && ex.z_we) begin
      zero_flag <= (ex.result == 8'h00);
    end else if (apb_wr && paddr == ccde_pkg::OFS_STATUS) begin
      zero_flag <= pwdata[ccde_pkg::ST_Z];
    end
  end

  // page select bits, software owned
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      page <= ccde_pkg::STATUS_RST[ccde_pkg::ST_PA_HI:ccde_pkg::ST_PA_LO];
    end else if (apb_wr && paddr == ccde_pkg::OFS_STATUS) begin
      page <= pwdata[ccde_pkg::ST_PA_HI:ccde_pkg::ST_PA_LO];
    end
  end

  // timeout and powerdown flags; the clear instruction wins over a timeout
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else if (exec && ex.wd_clear) begin
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else if (wd_wrap) begin
      timeout_flag_n <= 1'b0;
    end
  end

  // status word assembled from its owners, one driver each
  always_comb begin
    status                                        = 8'h00;
    status[ccde_pkg::ST_Z]                        = zero_flag;
    status[ccde_pkg::ST_PA_HI:ccde_pkg::ST_PA_LO] = page;
    status[ccde_pkg::ST_TO_N]                     = timeout_flag_n;
    status[ccde_pkg::ST_PD_N]                     = powerdown_flag_n;
  end

  // watchdog steps each cycle, or on prescaler wrap when assigned to it
  assign wd_tick = ctrl[ccde_pkg::CT_WDEN] &&
                   (!ctrl[ccde_pkg::CT_PSA] || prescaler == {PRESC_W{1'b1}});
  assign wd_wrap = wd_tick && (watchdog_counter == {WDOG_W{1'b1}}) && !(exec && ex.wd_clear);

  // shared prescaler; cleared only while assigned to the watchdog
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescaler <= '0;
    end else if (exec && ex.wd_clear && ctrl[ccde_pkg::CT_PSA]) begin
      prescaler <= '0;
    end else begin
      prescaler <= prescaler + 1'b1;
    end
  end

  // watchdog counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_counter <= '0;
    end else if (exec && ex.wd_clear) begin
      watchdog_counter <= '0;
    end else if (wd_tick) begin
      watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // event pulses
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_timeout <= 1'b0;
      watchdog_cleared <= 1'b0;
    end else begin
      watchdog_timeout <= wd_wrap;
      watchdog_cleared <= exec && ex.wd_clear;
    end
  end

endmodule // ccde_core
`default_nettype wire

// ---- sim/ccde_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// port checks on the execution core
module ccde_sva (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // program memory and stack
  input wire logic [10:0] instr_addr,
  input wire logic [11:0] instr_data,
  input wire logic        stack_push,
  input wire logic [10:0] stack_data,
  // file registers and watchdog
  input wire logic [4:0]  file_addr,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic        watchdog_cleared
);
  logic [11:0] d;
  logic [7:0]  k;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // word in execute, call operand one cycle later
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      d <= 12'h000;
      k <= 8'h00;
    end else begin
      d <= instr_data;
      k <= d[7:0];
    end
  end
  property p_push; stack_push |-> stack_data == instr_addr; endproperty
  a_push: assert property (p_push) else $error("bad return address");
  property p_tgt; stack_push |=> instr_addr[8:0] == {1'b0, k}; endproperty
  a_tgt: assert property (p_tgt) else $error("bad call target");
  property p_flush; stack_push |=> !file_we && !stack_push; endproperty
  a_flush: assert property (p_flush) else $error("slot after call ran");
  property p_clr; file_we && d[11:5] == ccde_pkg::OPC_CLRFILE_HI |-> file_wdata == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clear file not zero");
  property p_comp; file_we && d[11:6] == ccde_pkg::OPC_COMP_HI |-> file_wdata == ~file_rdata; endproperty
  a_comp: assert property (p_comp) else $error("complement wrong");
  property p_dec;
    file_we && (d[11:6] == ccde_pkg::OPC_DEC_HI || d[11:6] == ccde_pkg::OPC_DECSKIP_HI)
      |-> file_wdata == file_rdata - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_dest; file_we |-> d[ccde_pkg::DEST_BIT] && file_addr == d[4:0]; endproperty
  a_dest: assert property (p_dest) else $error("bad file write target");
  property p_skip;
    file_we && d[11:6] == ccde_pkg::OPC_DECSKIP_HI && file_rdata == 8'h01 |=> !file_we && !stack_push;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped slot ran");
  property p_wd; watchdog_cleared |-> $past(d) == ccde_pkg::OPC_WDCLR; endproperty
  a_wd: assert property (p_wd) else $error("stray watchdog clear");
endmodule // ccde_sva
`default_nettype wire

// ---- sim/ccde_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// program memory and file register array beside the core
module ccde_mem (
  // clock
  input  wire logic        ref_clk,
  // program memory
  input  wire logic [10:0] instr_addr,
  output logic [11:0]      instr_data,
  // file registers
  input  wire logic [4:0]  file_addr,
  output logic [7:0]       file_rdata,
  input  wire logic [7:0]  file_wdata,
  input  wire logic        file_we
);
  logic [11:0] rom [2048];
  logic [7:0]  ram [32];
  // unused program words read as no-operation
  initial foreach (rom[i]) rom[i] = 12'h000;
  // same-cycle reads
  assign instr_data = rom[instr_addr];
  assign file_rdata = ram[file_addr];
  // write lands at the edge closing the execute cycle
  always @(posedge ref_clk) if (file_we) ram[file_addr] <= file_wdata;
endmodule // ccde_mem
`default_nettype wire

// ---- sim/ccde_core_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the execution core
module ccde_core_test;
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, file_we, stack_push, watchdog_timeout, watchdog_cleared;
  logic [10:0] instr_addr, stack_data;
  logic [11:0] instr_data;
  logic [4:0]  file_addr;
  logic [7:0]  file_rdata, file_wdata;
  logic [10:0] pushes [$];
  int          fail_count = 0;
  int          comparisons = 0;
  ccde_core ccde_core_inst (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_addr, .instr_data, .file_addr, .file_rdata, .file_wdata, .file_we,
    .stack_push, .stack_data, .watchdog_timeout, .watchdog_cleared);
  ccde_mem ccde_mem_inst (.ref_clk, .instr_addr, .instr_data, .file_addr, .file_rdata, .file_wdata,
    .file_we);
  // clock and return stack capture
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (stack_push === 1'b1) pushes.push_back(stack_data);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, wd, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
  endtask
  task automatic wait_push(input int n);
    repeat (200) if (pushes.size() < n) @(posedge ref_clk);
    chk("push count", 32'(n), 32'(pushes.size()));
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(ccde_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    rd(ccde_pkg::OFS_STATUS, 32'h18, "status reset");
    rd(ccde_pkg::OFS_PC, 32'h0, "pc reset");
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
    chk("unmapped err", 32'h1, {31'h0, e});
    wr(ccde_pkg::OFS_STATUS, 32'h0);
    rd(ccde_pkg::OFS_STATUS, 32'h18, "status ro bits");
    wr(ccde_pkg::OFS_ACCUM, 32'h33);
    rd(ccde_pkg::OFS_ACCUM, 32'h33, "accum rw");
    $display("t_regs done");
  endtask
  task automatic t_ops();
    logic [11:0] p [10] = '{12'h242, 12'h262, 12'h0C1, 12'h0E4, 12'h2E3,
                            12'h268, 12'h2C5, 12'h066, 12'h0E7, 12'h909};
    logic [7:0] f0 [9] = '{8'h00, 8'h01, 8'h5A, 8'h01, 8'h02, 8'h03, 8'h77, 8'h00, 8'h00};
    logic [7:0] f1 [9] = '{8'h00, 8'h01, 8'hA5, 8'h00, 8'h01, 8'h03, 8'h00, 8'hFF, 8'h00};
    foreach (p[i]) ccde_mem_inst.rom[i] = p[i];
    foreach (f0[i]) ccde_mem_inst.ram[i] = f0[i];
    pushes.delete();
    wr(ccde_pkg::OFS_CTRL, 32'h1);
    wait_push(1);
    chk("return addr", 32'h00A, 32'(pushes[0]));
    rd(ccde_pkg::OFS_ACCUM, 32'h02, "accum result");
    rd(ccde_pkg::OFS_STATUS, 32'h18, "zero flag");
    wr(ccde_pkg::OFS_CTRL, 32'h0);
    foreach (f1[i]) chk("file reg", 32'(f1[i]), 32'(ccde_mem_inst.ram[i]));
    $display("t_ops done");
  endtask
  task automatic t_wd();
    logic [31:0] r;
    logic e;
    wr(ccde_pkg::OFS_CTRL, 32'h4);
    repeat (600) if (watchdog_timeout !== 1'b1) @(posedge ref_clk);
    rd(ccde_pkg::OFS_STATUS, 32'h08, "timeout flag");
    ccde_mem_inst.rom[16] = 12'h040;
    ccde_mem_inst.rom[17] = 12'h004;
    ccde_mem_inst.rom[18] = 12'h940;
    ccde_mem_inst.rom[19] = 12'h268;
    ccde_mem_inst.rom[576] = 12'h940;
    wr(ccde_pkg::OFS_STATUS, 32'h20);
    wr(ccde_pkg::OFS_PC, 32'h10);
    pushes.delete();
    wr(ccde_pkg::OFS_CTRL, 32'h7);
    wait_push(2);
    apb(1'b0, ccde_pkg::OFS_WDOG, 32'h0, r, e);
    chk("watchdog count", 32'h0, 32'(r[7:0]));
    chk("prescaler small", 32'h1, {31'h0, r[15:8] < 8'h20});
    rd(ccde_pkg::OFS_ACCUM, 32'h0, "accum clear");
    rd(ccde_pkg::OFS_STATUS, 32'h3C, "status after call");
    chk("first push", 32'h013, 32'(pushes[0]));
    chk("paged push", 32'h241, 32'(pushes[1]));
    chk("discarded slot", 32'h0, 32'(ccde_mem_inst.ram[8]));
    wr(ccde_pkg::OFS_CTRL, 32'h0);
    $display("t_wd done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_ops();
    t_wd();
    end_sim();
  end
  // hang guard
  initial begin
    repeat (4000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
endmodule // ccde_core_test
bind ccde_core ccde_sva ccde_sva_inst (.ref_clk, .arst_n, .instr_addr, .instr_data, .stack_push,
  .stack_data, .file_addr, .file_rdata, .file_wdata, .file_we, .watchdog_cleared);
`default_nettype wire
